// *** core/e3oh_framer_end.sv ***
`timescale 1ns/1ps
module e3oh_framer_end
   import e3oh_pkg::*;
(
   // Clocks and reset
   input  wire logic  recovered_line_clock,
   input  wire logic  local_tx_input_clock,
   input  wire logic  loop_timing_in,
   input  wire logic  mclk_in,
   input  wire logic  rst_b_in,
   // Overhead words from the receive framer
   input  wire logic  [11:0] frame_overhead_in,
   input  wire logic         frame_valid_in,
   output logic              frame_ready_out,
   // Link
   e3oh_if.framer            link,
   output logic              rx_section_out_clock
);
   import e3oh_pkg::*;

   // Section clock select; both sources run at 34.368 MHz for E3.
   // A plain mux can glitch when the timing mode flips, so the mode
   // is meant to change only while the far end ignores the link.
   assign rx_section_out_clock = loop_timing_in ?
                                 recovered_line_clock :
                                 local_tx_input_clock;

   // Timing of one overhead bit on the link, in mclk_in cycles:
   //   cycle 1  new bit appears; the marker follows the bit index
   //   cycle 2  bit settles at the far end
   //   cycle 3  sample strobe high; the bit has stood for two clocks
   //   cycle 4  bit still held, so a late capture still sees it
   // Twelve bits make a frame of 48 cycles; one reload cycle with the
   // data low separates frames when words arrive back to back.
   // The strobe is never closer than four clocks to the previous one,
   // so a far end that counts pulses cannot see two in one bit.

   // Last clock of an overhead bit; shared by every shifter register
   function automatic logic last_phase(input logic [1:0] ph);
      return (ph == 2'(E3OH_BIT_CYCLES - 1));
   endfunction

   // Bit index of the N bit, the last one of the frame
   function automatic logic last_bit(input logic [3:0] idx);
      return (idx == 4'(E3OH_IDX_N));
   endfunction

   // Pointer step of the two-entry buffer
   function automatic logic step_ptr(input logic ptr);
      return ~ptr;
   endfunction

   // Two-entry buffer so a late shifter loses no frame word
   logic [11:0] buf_mem [2];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  count;
   logic        push;
   logic        pop;

   // Ready only while an entry is free; a full buffer refuses words
   assign frame_ready_out = (count != 2'h2);
   assign push            = frame_valid_in && frame_ready_out;

   // Write pointer moves on every accepted word
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wr_ptr <= 1'b0;
      end else if (push) begin
         wr_ptr <= step_ptr(wr_ptr);
      end
   end

   // Read pointer moves when the shifter takes a word
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_ptr <= 1'b0;
      end else if (pop) begin
         rd_ptr <= step_ptr(rd_ptr);
      end
   end

   // Fill level; a push and a pop in one cycle leave it unchanged
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         count <= 2'h0;
      end else begin
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

   // Storage has no reset; the fill level guards every read
   always_ff @(posedge mclk_in) begin
      if (push) begin
         buf_mem[wr_ptr] <= frame_overhead_in;
      end
   end

   // Shifter: holds each bit for a fixed number of clocks
   e3oh_state_type state;
   e3oh_state_type next_state;
   logic [11:0]    shreg;
   logic [3:0]     bit_idx;
   logic [1:0]     phase;
   logic           shifting;
   logic           bit_end;

   // A word is taken only between frames; an illegal state takes none,
   // so a stray state code cannot swallow a buffered word
   assign shifting = (state == E3OH_SHIFT);
   assign pop      = ((state == E3OH_IDLE) || (state == E3OH_WAIT)) &&
                     (count != 2'h0);
   assign bit_end  = shifting && last_phase(phase);

   // Next state: load, shift twelve bits, then wait for the next word
   always_comb begin
      next_state = state;
      case (state)
         E3OH_IDLE, E3OH_WAIT: begin
            if (pop) begin
               next_state = E3OH_SHIFT;
            end
         end
         E3OH_SHIFT: begin
            if (bit_end && last_bit(bit_idx)) begin
               next_state = E3OH_WAIT;
            end
         end
         default: begin
            next_state = E3OH_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= E3OH_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Phase within the bit; restarts at each load and each bit end
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase <= 2'h0;
      end else if (pop || bit_end) begin
         phase <= 2'h0;
      end else if (shifting) begin
         phase <= phase + 2'h1;
      end
   end

   // Bit index; stays on the N bit until the next load
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bit_idx <= E3OH_IDX_RST;
      end else if (pop) begin
         bit_idx <= E3OH_IDX_RST;
      end else if (bit_end && !last_bit(bit_idx)) begin
         bit_idx <= bit_idx + 4'h1;
      end
   end

   // Shift register, first bit in the top position
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         shreg <= E3OH_FRAME_RST;
      end else if (pop) begin
         shreg <= buf_mem[rd_ptr];
      end else if (bit_end) begin
         shreg <= {shreg[10:0], 1'b0};
      end
   end

   // Next output values; data is idle low between frames, never left
   // undriven, so the far end always reads a defined level
   logic next_bit;
   logic next_strobe;
   logic next_marker;
   assign next_bit    = shifting ? shreg[11] : 1'b0;
   // Mid-bit pulse, two clocks after the bit appears
   assign next_strobe = shifting && (phase == 2'(E3OH_STROBE_POS));
   assign next_marker = shifting && (bit_idx == E3OH_IDX_RST);

   // Data output register
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link.overhead_bit <= 1'b0;
      end else begin
         link.overhead_bit <= next_bit;
      end
   end

   // Strobe output register
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link.overhead_sample_strobe <= 1'b0;
      end else begin
         link.overhead_sample_strobe <= next_strobe;
      end
   end

   // Marker output register, high across the whole first bit
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link.overhead_frame_marker <= 1'b0;
      end else begin
         link.overhead_frame_marker <= next_marker;
      end
   end
endmodule // e3oh_framer_end

// *** core/e3oh_terminal_end.sv ***
`timescale 1ns/1ps
module e3oh_terminal_end
   import e3oh_pkg::*;
(
   // Clock and reset
   input  wire logic         mclk_in,
   input  wire logic         rst_b_in,
   // Link
   e3oh_if.terminal          link,
   // Decoded overhead
   output logic [9:0]        frame_alignment_word_out,
   output logic              a_bit_out,
   output logic              n_bit_out,
   output logic              frame_done_out
);
   import e3oh_pkg::*;

   // The link comes from flops on this same clock, so it is read
   // directly; the strobe lasts one clock, so each high is one capture
   logic       take;
   logic       mark;
   logic       dat;
   logic [3:0] cnt;
   logic       synced;
   assign take = link.overhead_sample_strobe;
   assign mark = link.overhead_frame_marker;
   assign dat  = link.overhead_bit;
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt    <= E3OH_IDX_RST;
         synced <= 1'b0;
         frame_alignment_word_out <= 10'h000;
         a_bit_out      <= 1'b0;
         n_bit_out      <= 1'b0;
         frame_done_out <= 1'b0;
      end else begin
         frame_done_out <= 1'b0;
         if (take) begin
            if (mark) begin
               cnt    <= 4'h1;
               synced <= 1'b1;
               frame_alignment_word_out[9] <= dat;
            end else if (synced && cnt < 4'(E3OH_BITS_PER_FRM)) begin
               cnt <= cnt + 4'h1;
               if (cnt < 4'(E3OH_ALIGN_BITS))
                  frame_alignment_word_out[4'h9 - cnt] <= dat;
               else if (cnt == 4'(E3OH_IDX_A)) a_bit_out <= dat;
               else begin
                  n_bit_out      <= dat;
                  frame_done_out <= 1'b1;
               end
            end
         end
      end
   end
endmodule // e3oh_terminal_end

// *** pkg/e3oh_if.sv ***
`timescale 1ns/1ps
// Overhead link between framer end and terminal end
interface e3oh_if;
   logic overhead_bit;
   logic overhead_sample_strobe;
   logic overhead_frame_marker;
   modport framer   (output overhead_bit, output overhead_sample_strobe,
                     output overhead_frame_marker);
   modport terminal (input overhead_bit, input overhead_sample_strobe,
                     input overhead_frame_marker);
endinterface

// *** pkg/e3oh_pkg.sv ***
// Behaviour
// - Overhead bits leave serially, one at a time
// - One-clock strobe near middle of each bit
// - Strobe only while data is stable
// - Terminal captures data when strobe seen high
// - Frame marker high across first overhead bit
// - Section clock from line or local clock
// - Terminal samples marker only with strobe high
// - Terminal counts strobes since marker seen high
// - Counts 0-9 alignment bits 9..0, 10 A, 11 N
// - Overhead data output is always driven
package e3oh_pkg;
   // Overhead bits per frame: ten alignment, A, N
   localparam int E3OH_ALIGN_BITS   = 10;
   localparam int E3OH_BITS_PER_FRM = 12;
   localparam int E3OH_IDX_A        = 10;
   localparam int E3OH_IDX_N        = 11;
   // mclk_in periods per overhead bit and strobe position
   localparam int E3OH_BIT_CYCLES   = 4;
   localparam int E3OH_STROBE_POS   = 2;
   // Reset values
   localparam logic [11:0] E3OH_FRAME_RST = 12'h000;
   localparam logic [3:0]  E3OH_IDX_RST   = 4'h0;

   typedef enum logic [2:0] {
      E3OH_IDLE  = 3'b001,
      E3OH_SHIFT = 3'b010,
      E3OH_WAIT  = 3'b100
   } e3oh_state_type;
endpackage

// *** sim/e3oh_link_monitor.sv ***
`timescale 1ns/1ps
module e3oh_link_monitor (
   // Clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_b_in,
   // Link
   input  wire logic overhead_bit,
   input  wire logic overhead_sample_strobe,
   input  wire logic overhead_frame_marker
);
   logic [3:0] stb_cnt;
   wire        stb = overhead_sample_strobe;
   wire        mrk = overhead_frame_marker;
   wire        dat = overhead_bit;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   // Strobes since the last marked one; 0 only before the first frame
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         stb_cnt <= 4'h0;
      else if (stb)
         stb_cnt <= mrk ? 4'h1 : stb_cnt + 4'h1;
   end
   AST_STB_ONE: assert property (stb |=> !stb[*3])
      else $error("strobe too close");
   AST_DAT_HELD: assert property (stb |-> $stable(dat))
      else $error("data moved into strobe");
   AST_DAT_AFTER: assert property (stb |=> $stable(dat))
      else $error("data moved after strobe");
   AST_MRK_LEN: assert property ($rose(mrk) |-> mrk[*4] ##1 !mrk)
      else $error("marker length wrong");
   AST_MRK_STB: assert property ($rose(mrk) |-> ##2 stb)
      else $error("no strobe mid first bit");
   AST_MRK_NEXT: assert property ($fell(mrk) |-> ##2 stb)
      else $error("no strobe mid second bit");
   AST_FRM_TWELVE: assert property (
      stb && mrk |-> stb_cnt inside {0, 12})
      else $error("frame not twelve bits");
   AST_CNT_RANGE: assert property (
      stb && !mrk |-> stb_cnt inside {[1:11]})
      else $error("strobe outside frame");
endmodule // e3oh_link_monitor

// *** sim/test_e3_rx_overhead_strobed_output.sv ***
`timescale 1ns/1ps
module test_e3_rx_overhead_strobed_output;
   import e3oh_pkg::*;
   logic        mclk_in = 0, rst_b_in = 0, line_clk = 0, local_clk = 0;
   logic        loop = 0, valid = 0, feed = 1;
   logic        ready, sec_clk, a_bit, n_bit, done;
   logic [11:0] word = 12'h000;
   logic [9:0]  faw;
   logic [11:0] q[$];
   integer      seed = 97887, err_total = 0, n_tests = 0;
   // Source clocks chosen so no edge lands on a mux check
   always #5 mclk_in = ~mclk_in;
   always #7.5 line_clk = ~line_clk;
   always #4.5 local_clk = ~local_clk;
   e3oh_if link();
   e3oh_framer_end e3oh_framer_end_i (.recovered_line_clock(line_clk),
      .local_tx_input_clock(local_clk), .loop_timing_in(loop), .mclk_in,
      .rst_b_in, .frame_overhead_in(word), .frame_valid_in(valid),
      .frame_ready_out(ready), .link(link), .rx_section_out_clock(sec_clk));
   e3oh_terminal_end e3oh_terminal_end_i (.mclk_in, .rst_b_in, .link(link),
      .frame_alignment_word_out(faw), .a_bit_out(a_bit), .n_bit_out(n_bit),
      .frame_done_out(done));
   e3oh_link_monitor e3oh_link_monitor_i (.mclk_in, .rst_b_in,
      .overhead_bit(link.overhead_bit),
      .overhead_sample_strobe(link.overhead_sample_strobe),
      .overhead_frame_marker(link.overhead_frame_marker));
   task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %0t word %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk_clk(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %0t section clock %b", $time, got);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Model: accepted words come back whole and in order
   always @(posedge mclk_in) begin
      if (rst_b_in && valid && ready)
         q.push_back(word);
      if (done)
         chk_word({faw, a_bit, n_bit},
                  q.size() ? q.pop_front() : 12'hfff);
   end
   // Random stimulus; valid often high so the buffer fills and refuses
   always @(negedge mclk_in) begin
      valid = feed & rst_b_in & 1'($random(seed));
      word = 12'($random(seed));
      loop = 1'($random(seed));
      #1.1 chk_clk(sec_clk, loop ? line_clk : local_clk);
   end
   initial begin
      repeat (10) @(posedge mclk_in);
      @(negedge mclk_in) rst_b_in = 1;
      repeat (1500) @(posedge mclk_in);
      feed = 0;
      repeat (200) @(posedge mclk_in);
      chk_word(12'(q.size()), 12'h000);
      stop_test();
   end
   // Watchdog well past the expected run of about 1700 cycles
   initial begin
      #100000;
      err_total++;
      stop_test();
   end
endmodule // test_e3_rx_overhead_strobed_output
